// file: verilog/spsc_consts.vh
// Constants for the parallel-side control of the 16-bit serdes.
// Assumes inclusion by bare name from every design file of the block.
`ifndef SPSC_CONSTS_VH
`define SPSC_CONSTS_VH

// Word and symbol geometry
`define SPSC_WORD_W       16
`define SPSC_BYTE_W       8
`define SPSC_SYM_W        10
`define SPSC_LINE_W       20
`define SPSC_K_BIT        8
`define SPSC_PAR_BIT      9

// Clock and power-on reset timing
`define SPSC_CLK_NS       40
`define SPSC_POR_NS       1000
`define SPSC_POR_CYC      ((`SPSC_POR_NS + `SPSC_CLK_NS - 1) / `SPSC_CLK_NS)
`define SPSC_POR_CNT_W    6

// Receiver lock: consecutive good words before tracking data
`define SPSC_LOCK_CYC     4'h8
`define SPSC_LOCK_CNT_W   4

// Test pattern: 16-bit LFSR, taps, seed and pass threshold
`define SPSC_PRBS_TAPS    16'hB400
`define SPSC_PRBS_SEED    16'hACE1
`define SPSC_PASS_CNT     4'h4
`define SPSC_PASS_CNT_W   4

`endif

// file: verilog/spsc_prbs.v
// Test-pattern generator and checker for the parallel-side control.
// Assumes one clock; advance and check strobes come from that clock.
`timescale 1ns/1ps
`include "spsc_consts.vh"

module spsc_prbs (
	input  wire                      clock,
	input  wire                      arst_n,
	input  wire                      advance,
	input  wire                      checkEnable,
	input  wire [`SPSC_WORD_W-1:0]   rxWord,
	input  wire                      rxWordValid,
	output reg  [`SPSC_WORD_W-1:0]   genWord,
	output reg                       pass
);

	// Matches seen in a row, saturating
	reg [`SPSC_PASS_CNT_W-1:0] matchCount;
	// Previous received word, predicts the next
	reg [`SPSC_WORD_W-1:0]     prevRx;

	////////////////////////////////////////////////////////////////////////
	// Sixteen LFSR steps per word, shared by both directions
	function [`SPSC_WORD_W-1:0] prbsNext;
		input [`SPSC_WORD_W-1:0] s;
		integer i;
		reg [`SPSC_WORD_W-1:0] t;
		begin
			t = s;
			for (i = 0; i < `SPSC_WORD_W; i = i + 1)
			begin
				t = {t[`SPSC_WORD_W-2:0], ^(t & `SPSC_PRBS_TAPS)};
			end
			prbsNext = t;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Generator: free-runs only while words are being sent
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			genWord <= `SPSC_PRBS_SEED;
		else if (advance)
			genWord <= prbsNext(genWord);
	end

	////////////////////////////////////////////////////////////////////////
	// Checker: self-seeding, so no alignment with the far generator needed
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			matchCount <= {`SPSC_PASS_CNT_W{1'b0}};
			prevRx     <= {`SPSC_WORD_W{1'b0}};
			pass       <= 1'b0;
		end
		else if (!checkEnable)
		begin
			// Disabled: forget history so a stale pass cannot show
			matchCount <= {`SPSC_PASS_CNT_W{1'b0}};
			pass       <= 1'b0;
		end
		else if (rxWordValid)
		begin
			prevRx <= rxWord;
			// All-zero words would match forever, so they never count
			if (rxWord == prbsNext(prevRx) && rxWord != {`SPSC_WORD_W{1'b0}})
			begin
				if (matchCount != `SPSC_PASS_CNT)
					matchCount <= matchCount + 1'b1;
				pass <= (matchCount >= `SPSC_PASS_CNT - 1'b1);
			end
			else
			begin
				matchCount <= {`SPSC_PASS_CNT_W{1'b0}};
				pass       <= 1'b0;
			end
		end
	end

endmodule // spsc_prbs

// file: verilog/spsc_parallel_side.v
// Parallel-side pins and mode control of a 16-bit serializer/deserializer.
// Assumes clock is the reference word clock; serial lines carry one
// 20-bit line word (two 10-bit symbols, bit 0 first) per clock.
`timescale 1ns/1ps
`include "spsc_consts.vh"

module spsc_parallel_side (
	input  wire                      clock,
	input  wire                      arst_n,
	input  wire                      deviceEnable,
	input  wire                      lockToRefN,
	input  wire                      loopbackEnable,
	input  wire                      testPatternEnable,
	input  wire [`SPSC_WORD_W-1:0]   txData,
	input  wire                      txKcodeLowByte,
	input  wire                      txKcodeHighByte,
	input  wire [`SPSC_LINE_W-1:0]   serialRxPos,
	input  wire [`SPSC_LINE_W-1:0]   serialRxNeg,
	output reg  [`SPSC_LINE_W-1:0]   serialTxPos,
	output reg  [`SPSC_LINE_W-1:0]   serialTxNeg,
	output reg                       serialTxOe,
	output reg  [`SPSC_WORD_W-1:0]   rxData,
	output reg                       rxDataOe,
	output reg                       rxKcodeLowByte,
	output reg                       rxKcodeHighByte,
	output reg                       rxKcodeOe,
	output reg                       recoveredClock,
	output reg                       recoveredClockOe,
	output reg                       signalDetect
);

	// Power states, one-hot
	localparam [2:0] ST_DOWN = 3'b001;
	localparam [2:0] ST_POR  = 3'b010;
	localparam [2:0] ST_RUN  = 3'b100;

	// Mode pin synchronisers: enable, lock, loopback, test
	reg  [3:0]                 ctlMeta;
	reg  [3:0]                 ctlSync;
	// Serial receive synchronisers
	reg  [`SPSC_LINE_W-1:0]    rxMetaPos;
	reg  [`SPSC_LINE_W-1:0]    rxMetaNeg;
	reg  [`SPSC_LINE_W-1:0]    rxSyncPos;
	reg  [`SPSC_LINE_W-1:0]    rxSyncNeg;
	// Power sequencing
	reg  [2:0]                 state;
	reg  [2:0]                 next_state;
	reg  [`SPSC_POR_CNT_W-1:0] porCount;
	// Receiver lock tracking
	reg  [`SPSC_LOCK_CNT_W-1:0] lockCount;

	// Synchronised mode levels
	wire                       enSync   = ctlSync[3];
	wire                       lockSync = ctlSync[2];
	wire                       loopSync = ctlSync[1];
	wire                       testSync = ctlSync[0];
	wire                       running  = (state == ST_RUN);

	// Receive path selection and decode
	wire [`SPSC_LINE_W-1:0]    rxLine;
	wire                       rxLineOk;
	wire                       symOk;
	wire                       locked;
	wire                       wordStrobe;
	// Test pattern hookup
	wire [`SPSC_WORD_W-1:0]    genWord;
	wire                       patternPass;
	wire [`SPSC_WORD_W-1:0]    txPayload;

	////////////////////////////////////////////////////////////////////////
	// Symbol coding: odd parity, K flag, byte. Stands in for the real
	// line code; it keeps the K/D distinction and a validity check.
	function [`SPSC_SYM_W-1:0] encSym;
		input                    kFlag;
		input [`SPSC_BYTE_W-1:0] dataByte;
		begin
			encSym = {~(^{kFlag, dataByte}), kFlag, dataByte};
		end
	endfunction

	// Symbol is valid when its parity is odd
	function symValid;
		input [`SPSC_SYM_W-1:0] sym;
		begin
			symValid = ^sym;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Two-stage synchronisers for pins from outside the clock domain
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctlMeta   <= 4'h0;
			ctlSync   <= 4'h0;
			rxMetaPos <= {`SPSC_LINE_W{1'b0}};
			rxMetaNeg <= {`SPSC_LINE_W{1'b0}};
			rxSyncPos <= {`SPSC_LINE_W{1'b0}};
			rxSyncNeg <= {`SPSC_LINE_W{1'b0}};
		end
		else
		begin
			ctlMeta   <= {deviceEnable, lockToRefN, loopbackEnable,
				testPatternEnable};
			ctlSync   <= ctlMeta;
			rxMetaPos <= serialRxPos;
			rxMetaNeg <= serialRxNeg;
			rxSyncPos <= rxMetaPos;
			rxSyncNeg <= rxMetaNeg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power state: enable low parks in power-down from any state
	always @*
	begin
		next_state = state;
		case (state)
			ST_DOWN:
				if (enSync)
					next_state = ST_POR;
			ST_POR:
				if (!enSync)
					next_state = ST_DOWN;
				else if (porCount == `SPSC_POR_CYC - 1)
					next_state = ST_RUN;
			ST_RUN:
				if (!enSync)
					next_state = ST_DOWN;
			default:
				next_state = ST_POR;
		endcase
	end

	// State register; reset release enters power-on reset
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state    <= ST_POR;
			porCount <= {`SPSC_POR_CNT_W{1'b0}};
		end
		else
		begin
			state <= next_state;
			// Counter restarts on every fresh entry into reset
			if (state == ST_POR && next_state == ST_POR)
				porCount <= porCount + 1'b1;
			else
				porCount <= {`SPSC_POR_CNT_W{1'b0}};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit: pattern generator replaces user data in test mode
	assign txPayload = testSync ? genWord : txData;

	// Word captured every edge while running and sent as one 20-bit line word
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			serialTxPos <= {`SPSC_LINE_W{1'b0}};
			serialTxNeg <= {`SPSC_LINE_W{1'b0}};
			serialTxOe  <= 1'b0;
		end
		else
		begin
			if (running)
			begin
				// Low byte symbol sits in the low bits, sent first
				serialTxPos <= {
					encSym(txKcodeHighByte & ~testSync,
						txPayload[`SPSC_WORD_W-1:`SPSC_BYTE_W]),
					encSym(txKcodeLowByte & ~testSync,
						txPayload[`SPSC_BYTE_W-1:0])};
				serialTxNeg <= ~{
					encSym(txKcodeHighByte & ~testSync,
						txPayload[`SPSC_WORD_W-1:`SPSC_BYTE_W]),
					encSym(txKcodeLowByte & ~testSync,
						txPayload[`SPSC_BYTE_W-1:0])};
			end
			else
			begin
				serialTxPos <= {`SPSC_LINE_W{1'b0}};
				serialTxNeg <= {`SPSC_LINE_W{1'b0}};
			end
			// Driven only when running and not looped back
			serialTxOe <= running & ~loopSync;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive source: own transmit stream in loopback, else the pins
	assign rxLine   = loopSync ? serialTxPos : rxSyncPos;
	// External pair must be truly differential on every bit
	assign rxLineOk = loopSync | (rxSyncPos == ~rxSyncNeg);
	assign symOk    = rxLineOk
		& symValid(rxLine[`SPSC_SYM_W-1:0])
		& symValid(rxLine[`SPSC_LINE_W-1:`SPSC_SYM_W]);
	assign locked   = (lockCount == `SPSC_LOCK_CYC);
	// A word is delivered only while tracking the data stream
	assign wordStrobe = running & lockSync & locked & symOk;

	// Lock tracking; held clear while locked to the reference
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			lockCount <= {`SPSC_LOCK_CNT_W{1'b0}};
		else if (!running || !lockSync || !symOk)
			lockCount <= {`SPSC_LOCK_CNT_W{1'b0}};
		else if (!locked)
			lockCount <= lockCount + 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Test pattern generator and checker
	spsc_prbs uPrbs (
		.clock       (clock),
		.arst_n      (arst_n),
		.advance     (running & testSync),
		.checkEnable (testSync),
		.rxWord      ({rxLine[`SPSC_SYM_W+`SPSC_BYTE_W-1:`SPSC_SYM_W],
			rxLine[`SPSC_BYTE_W-1:0]}),
		.rxWordValid (wordStrobe),
		.genWord     (genWord),
		.pass        (patternPass)
	);

	////////////////////////////////////////////////////////////////////////
	// Receive outputs and their enables
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rxData           <= {`SPSC_WORD_W{1'b0}};
			rxDataOe         <= 1'b0;
			rxKcodeLowByte   <= 1'b0;
			rxKcodeHighByte  <= 1'b0;
			rxKcodeOe        <= 1'b0;
			recoveredClock   <= 1'b0;
			recoveredClockOe <= 1'b0;
		end
		else
		begin
			// Floated in reset, power-down and transmit-only mode
			rxDataOe  <= running & lockSync;
			rxKcodeOe <= running & lockSync;
			// Clock pin is driven low during power-on reset
			recoveredClockOe <= (state == ST_POR) | (running & lockSync);
			// One high cycle per delivered word, data stable with it
			recoveredClock <= wordStrobe;
			if (wordStrobe)
			begin
				rxData <= {rxLine[`SPSC_SYM_W+`SPSC_BYTE_W-1:`SPSC_SYM_W],
					rxLine[`SPSC_BYTE_W-1:0]};
				rxKcodeHighByte <= rxLine[`SPSC_SYM_W + `SPSC_K_BIT];
			end
			// Low K pin doubles as pattern result in test mode
			if (testSync)
				rxKcodeLowByte <= patternPass;
			else if (wordStrobe)
				rxKcodeLowByte <= rxLine[`SPSC_K_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Signal detect stays alive in every state, power-down included
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			signalDetect <= 1'b0;
		else
			signalDetect <= |(rxSyncPos ^ rxSyncNeg);
	end

endmodule // spsc_parallel_side

// file: verification/spsc_parallel_side_asserts.sv
// Checker for the parallel-side control, watching top-level ports only.
// Assumes one reference clock and mode pins synced in two stages.
`timescale 1ns/1ps
module spsc_parallel_side_asserts (
	input wire        clock,
	input wire        arst_n,
	input wire        deviceEnable,
	input wire        lockToRefN,
	input wire        loopbackEnable,
	input wire        testPatternEnable,
	input wire [15:0] txData,
	input wire        txKcodeLowByte,
	input wire [19:0] serialRxPos,
	input wire [19:0] serialRxNeg,
	input wire [19:0] serialTxPos,
	input wire [19:0] serialTxNeg,
	input wire        serialTxOe,
	input wire        rxDataOe,
	input wire        rxKcodeOe,
	input wire        recoveredClock,
	input wire        recoveredClockOe,
	input wire        signalDetect
);
	// Mode pins need three edges, four for enable, so five samples leave margin for all but enable
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	chk_tx_pair_inverse: assert property (serialTxOe |->
		serialTxNeg == ~serialTxPos) else $error("tx pair not inverse");
	chk_tx_float_loop: assert property (loopbackEnable[*5] |->
		!serialTxOe) else $error("tx driven in loopback");
	chk_tx_word_capture: assert property ((!testPatternEnable)[*4]
		##0 serialTxOe && $past(serialTxOe) |->
		serialTxPos[7:0] == $past(txData[7:0]) &&
		serialTxPos[17:10] == $past(txData[15:8]) &&
		serialTxPos[8] == $past(txKcodeLowByte))
		else $error("tx word not from previous edge");
	chk_rx_float_lock: assert property ((!lockToRefN)[*5] |->
		!rxDataOe && !rxKcodeOe) else $error("rx driven, lock low");
	chk_down_quiet: assert property ((!deviceEnable)[*5] |->
		!serialTxOe && !rxDataOe && !recoveredClockOe)
		else $error("outputs driven in power-down");
	chk_por_outputs_low: assert property (recoveredClockOe &&
		!rxDataOe |-> !recoveredClock && !serialTxOe)
		else $error("clock or tx active in power-on reset");
	chk_sig_detect_on: assert property ((serialRxPos !=
		serialRxNeg)[*5] |-> signalDetect) else $error("signal missed");
	chk_sig_detect_off: assert property ((serialRxPos ==
		serialRxNeg)[*5] |-> !signalDetect) else $error("false signal");
	chk_rx_clock_oe: assert property (recoveredClock |->
		rxDataOe && rxKcodeOe) else $error("word with rx floating");
endmodule // spsc_parallel_side_asserts
bind spsc_parallel_side spsc_parallel_side_asserts chk (.*);

// file: verification/spsc_far_end.sv
// Far-end link source feeding line words to the serial inputs.
// Assumes the reference clock; lines change just after rising edges.
`timescale 1ns/1ps
module spsc_far_end (
	input  wire        clock,
	input  wire [15:0] word,
	input  wire        kLow,
	input  wire        kHigh,
	input  wire        corrupt,
	output reg  [19:0] pos = 20'h00000,
	output reg  [19:0] neg = 20'hFFFFF
);
	// Symbol is odd parity, K flag, byte
	function [9:0] sym(input k, input [7:0] b);
		sym = {~^{k, b}, k, b};
	endfunction
	// Low lane in bits 9:0, high lane above
	function [19:0] line(input [15:0] w, input kl, input kh);
		line = {sym(kh, w[15:8]), sym(kl, w[7:0])};
	endfunction
	// Shorting the pair breaks lock and signal detect
	always @(posedge clock)
	begin
		pos <= #1 line(word, kLow, kHigh);
		neg <= #1 corrupt ? pos : ~line(word, kLow, kHigh);
	end
endmodule // spsc_far_end

// file: verification/spsc_tb.sv
// Bench for the parallel-side control; pins change at falling edges.
// Assumes the far-end model feeds the serial inputs.
`timescale 1ns/1ps
module tb;
	reg         clock = 1'b0;
	reg         arst_n = 1'b0;
	reg         enable = 1'b0, lockN = 1'b1, test = 1'b0;
	reg         loop = 1'b0;
	reg         kLow = 1'b0, kHigh = 1'b0, corrupt = 1'b0;
	reg  [15:0] txData = 16'h0000;
	wire [19:0] rxPos, rxNeg, txPos, txNeg;
	wire [15:0] rxData;
	wire        txOe, rxOe, rkLow, rkHigh, rkOe, rclk, rclkOe, sigDet;
	integer     fail_count = 0, checks = 0, cycles = 0, i;
	spsc_parallel_side uut (.clock(clock), .arst_n(arst_n),
		.deviceEnable(enable), .lockToRefN(lockN),
		.loopbackEnable(loop), .testPatternEnable(test),
		.txData(txData), .txKcodeLowByte(kLow), .txKcodeHighByte(kHigh),
		.serialRxPos(rxPos), .serialRxNeg(rxNeg), .serialTxPos(txPos),
		.serialTxNeg(txNeg), .serialTxOe(txOe), .rxData(rxData),
		.rxDataOe(rxOe), .rxKcodeLowByte(rkLow), .rxKcodeHighByte(rkHigh),
		.rxKcodeOe(rkOe), .recoveredClock(rclk),
		.recoveredClockOe(rclkOe), .signalDetect(sigDet));
	spsc_far_end farEnd (.clock(clock), .word(txData), .kLow(kLow),
		.kHigh(kHigh), .corrupt(corrupt), .pos(rxPos), .neg(rxNeg));
	// Reference clock, 25 MHz
	initial forever #20 clock = ~clock;
	// Hang guard, far above the few hundred cycles needed
	always @(posedge clock)
	begin
		cycles = cycles + 1;
		if (cycles == 3000)
		begin
			fail_count = fail_count + 1;
			end_of_test;
		end
	end
	task checkBit(input [8*8:1] name, input exp, input got);
	begin
		checks = checks + 1;
		if (got !== exp)
		begin
			fail_count = fail_count + 1;
			$display("[ERR] %0s exp %b got %b", name, exp, got);
		end
	end
	endtask
	task checkWord(input [8*8:1] name, input [19:0] exp, input [19:0] got);
	begin
		checks = checks + 1;
		if (got !== exp)
		begin
			fail_count = fail_count + 1;
			$display("[ERR] %0s exp %h got %h", name, exp, got);
		end
	end
	endtask
	task step(input integer n);
		repeat (n) @(negedge clock);
	endtask
	// Bounded wait for a delivered word
	task waitWord;
		integer n;
	begin
		for (n = 0; n < 40 && rclk !== 1'b1; n = n + 1)
			step(1);
	end
	endtask
	task end_of_test;
	begin
		if (fail_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask
	// Main sequence
	initial
	begin
		step(5);
		checkBit("txOe", 1'b0, txOe);
		checkBit("rxOe", 1'b0, rxOe);
		enable = 1'b1;
		arst_n = 1'b1;
		step(10);
		checkBit("rclkOe", 1'b1, rclkOe);
		checkBit("rclk", 1'b0, rclk);
		checkBit("txOe", 1'b0, txOe);
		checkBit("rxOe", 1'b0, rxOe);
		step(25);
		// Every lane K combination out on the line and back
		for (i = 0; i < 4; i = i + 1)
		begin
			txData = 16'h3A5C + i * 16'h1111;
			{kHigh, kLow} = i;
			step(2);
			checkWord("txPos", farEnd.line(txData, kLow, kHigh), txPos);
			checkWord("txNeg", ~farEnd.line(txData, kLow, kHigh), txNeg);
			checkBit("txOe", 1'b1, txOe);
			step(14);
			waitWord;
			checkBit("rclk", 1'b1, rclk);
			checkWord("rxData", {4'h0, txData}, {4'h0, rxData});
			checkBit("rxOe", 1'b1, rxOe);
			checkBit("rkLow", kLow, rkLow);
			checkBit("rkHigh", kHigh, rkHigh);
		end
		// Shorted pair: lock and signal lost
		corrupt = 1'b1;
		step(6);
		checkBit("sigDet", 1'b0, sigDet);
		checkBit("rclk", 1'b0, rclk);
		corrupt = 1'b0;
		lockN = 1'b0;
		step(5);
		checkBit("rxOe", 1'b0, rxOe);
		checkBit("rkOe", 1'b0, rkOe);
		checkBit("rclkOe", 1'b0, rclkOe);
		checkBit("txOe", 1'b1, txOe);
		// Loopback ignores the shorted far end
		lockN = 1'b1;
		loop = 1'b1;
		corrupt = 1'b1;
		txData = 16'hC3E7;
		// Low K set, so a pattern result of 0 is told apart from it
		kLow = 1'b1;
		step(5);
		checkBit("txOe", 1'b0, txOe);
		step(14);
		waitWord;
		checkWord("rxData", {4'h0, 16'hC3E7}, {4'h0, rxData});
		checkBit("rkLow", 1'b1, rkLow);
		test = 1'b1;
		// Pattern result replaces the K flag before any pass
		step(4);
		checkBit("rkLow", 1'b0, rkLow);
		for (i = 0; i < 60 && rkLow !== 1'b1; i = i + 1)
			step(1);
		checkBit("pass", 1'b1, rkLow);
		test = 1'b0;
		kLow = 1'b0;
		step(8);
		checkBit("rkLow", 1'b0, rkLow);
		// Power-down, then re-entry through power-on reset
		loop = 1'b0;
		corrupt = 1'b0;
		enable = 1'b0;
		step(6);
		checkBit("txOe", 1'b0, txOe);
		checkBit("rxOe", 1'b0, rxOe);
		checkBit("sigDet", 1'b1, sigDet);
		enable = 1'b1;
		step(6);
		checkBit("rclkOe", 1'b1, rclkOe);
		checkBit("txOe", 1'b0, txOe);
		step(32);
		checkBit("txOe", 1'b1, txOe);
		end_of_test;
	end
endmodule // tb
